// file: bench/t16tec_chk_sva.sv
// Purpose: port checks for the timer top
// Assumes: one sys_clk domain
// Notes:   only top ports are visible
`timescale 1ns/10ps
module t16tec_chk
	import t16tec_pkg::*;
(
	// clock and reset
	input wire logic       sys_clk,
	input wire logic       rst_b,
	// register port
	input wire logic [2:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic       reg_wr,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_rdata,
	// power, pin, interrupt
	input wire logic       stop_mode_enter,
	input wire logic       low_speed_mode,
	input wire logic       timer_input_pin,
	input wire logic       match_interrupt
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_b);

	wire ctl_wr  = reg_wr && reg_addr == REG_CTRL;
	wire stop_wr = ctl_wr && reg_wdata[6:5] == START_STOP;

	chk_irq_single: assert property (match_interrupt |=> !match_interrupt [*8])
		else $error("interrupt longer than one cycle");
	chk_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
		else $error("read data outside read slot");
	chk_aux_high_zero: assert property (reg_rd && reg_addr == REG_AUX |=> reg_rdata[7:3] == 5'h00)
		else $error("aux upper bits set");
	chk_stop_halt: assert property (stop_mode_enter ##1 !reg_wr [*8] |=> !match_interrupt)
		else $error("interrupt after stop entry");
	chk_stop_run_bit: assert property (stop_mode_enter ##1 !ctl_wr ##1
		(reg_rd && reg_addr == REG_AUX) |=> !reg_rdata[AUX_RUN_BIT])
		else $error("still running after stop entry");
	chk_halt_no_irq: assert property (stop_wr ##1 !reg_wr [*8] |=> !match_interrupt)
		else $error("interrupt while halted");
	// counter clears on the edge after the stop write lands, so read one cycle later
	chk_halt_cnt_zero: assert property (stop_wr ##2 (reg_rd && reg_addr == REG_CNT_LO)
		|=> reg_rdata == 8'h00)
		else $error("counter not cleared on stop");
	chk_ctrl_readback: assert property ((ctl_wr && !stop_mode_enter) ##1
		(reg_rd && reg_addr == REG_CTRL && !stop_mode_enter) |=> reg_rdata == $past(reg_wdata, 2))
		else $error("control readback differs");
endmodule : t16tec_chk

bind t16tec_top t16tec_chk t16tec_chk_i (.sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.stop_mode_enter(stop_mode_enter), .low_speed_mode(low_speed_mode),
	.timer_input_pin(timer_input_pin), .match_interrupt(match_interrupt));

// file: bench/t16tec_pulse_src.sv
// Purpose: external pulse source on the timer input pin
// Assumes: phases given in sys_clk cycles
// Notes:   short phases only when a test asks for a glitch or runs with the filter bypassed in low-speed mode
`timescale 1ns/10ps
module t16tec_pulse_src (
	// clock
	input  wire logic sys_clk,
	// driven pin
	output logic      pin
);
	initial pin = 1'b0;

	// normal phases are 34+ cycles so the filter always accepts them
	task automatic hold(input logic lvl, input int n);
		pin <= lvl;
		repeat (n) @(posedge sys_clk);
	endtask : hold
endmodule : t16tec_pulse_src

// file: bench/testbench.sv
// Purpose: self-checking bench for the 16-bit timer
// Assumes: prescale counts shortened to 8 and 12 cycles
// Notes:   strobes stay up until the next bus op or idle
`timescale 1ns/10ps
module testbench;
	import t16tec_pkg::*;
	localparam int C00 = 8;
	localparam int CSL = 12;
	logic       sys_clk, rst_b, reg_wr, reg_rd, stop_mode_enter, low_speed_mode, pin, irq;
	logic [2:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata;
	int         n_errors, check_count, irq_cnt;

	t16tec_top #(.SRC00_CYCLES(C00), .SRC_SLOW_CYCLES(CSL)) t16tec_top_i (.sys_clk(sys_clk),
		.rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .stop_mode_enter(stop_mode_enter),
		.low_speed_mode(low_speed_mode), .timer_input_pin(pin), .match_interrupt(irq));
	t16tec_pulse_src t16tec_pulse_src_i (.sys_clk(sys_clk), .pin(pin));

	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) if (irq === 1'b1) irq_cnt <= irq_cnt + 1;

	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask : check
	task automatic bus(input logic w, input logic [2:0] a, input logic [7:0] d,
		output logic [7:0] q);
		reg_wr    <= w;
		reg_rd    <= !w;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		#1 q = reg_rdata;
	endtask : bus
	task automatic idle(input int n);
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		repeat (n) @(posedge sys_clk);
		#1;
	endtask : idle
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		logic [7:0] q;
		bus(1'b1, a, d, q);
	endtask : wr
	task automatic rdchk(input logic [2:0] a, input logic [7:0] e);
		logic [7:0] q;
		bus(1'b0, a, 8'h00, q);
		check({8'h00, q}, {8'h00, e});
	endtask : rdchk
	task automatic run_ctl(input logic [7:0] v);
		wr(REG_CTRL, v & 8'h9f);
		wr(REG_CTRL, v);
	endtask : run_ctl
	task automatic pin_hold(input logic l, input int n);
		idle(0);
		t16tec_pulse_src_i.hold(l, n);
	endtask : pin_hold
	// cycles until the next interrupt pulse
	task automatic gap(output int n);
		n = 1;
		idle(1);
		while (irq !== 1'b1 && n < 4000) begin
			idle(1);
			n++;
		end
	endtask : gap

	task automatic t_reset();
		logic [7:0] e [8] = '{8'h00, 8'hff, 8'hff, 8'hff, 8'hff, 8'h00, 8'h00, 8'h00};
		for (int i = 0; i < 8; i++) rdchk(3'(i), e[i]);
		wr(REG_AUX, 8'h00);
	endtask : t_reset
	task automatic t_timer();
		logic [1:0] code [4] = '{2'h0, 2'h1, 2'h2, 2'h0};
		int         cyc  [4] = '{C00, SRC01_CYC, SRC10_CYC, CSL};
		int         n;
		wr(REG_PER_LO, 8'h03);
		rdchk(REG_PER_LO, 8'hff);
		wr(REG_PER_HI, 8'h00);
		idle(20);
		rdchk(REG_PER_LO, 8'h03);
		for (int i = 0; i < 4; i++) begin
			low_speed_mode <= (i == 3);
			run_ctl({1'b0, START_CMD, code[i], MODE_TIMER});
			gap(n);
			gap(n);
			check(16'(n), 16'(3 * cyc[i]));
			wr(REG_CTRL, 8'h00);
			idle(10);
		end
		low_speed_mode <= 1'b0;
	endtask : t_timer
	task automatic t_cap_stop();
		logic [7:0] q;
		int         c;
		run_ctl({1'b1, START_CMD, CLK_SEL_00, MODE_TIMER});
		rdchk(REG_CTRL, 8'ha0);
		idle(30);
		rdchk(REG_DUTY_HI, 8'h00);
		bus(1'b0, REG_DUTY_LO, 8'h00, q);
		check(16'(q < 8'h03), 16'h0001);
		stop_mode_enter <= 1'b1;
		idle(1);
		stop_mode_enter <= 1'b0;
		// a match on the stop edge itself is still legal; let its count land first
		idle(1);
		c = irq_cnt;
		rdchk(REG_AUX, 8'h00);
		rdchk(REG_CTRL, 8'h80);
		rdchk(REG_CNT_LO, 8'h00);
		idle(40);
		check(16'(irq_cnt - c), 16'h0000);
	endtask : t_cap_stop
	task automatic t_trig();
		int c;
		wr(REG_PER_LO, 8'h14);
		wr(REG_PER_HI, 8'h00);
		wr(REG_DUTY_LO, 8'h34);
		wr(REG_DUTY_HI, 8'h12);
		run_ctl({1'b1, START_RISE, CLK_SEL_00, MODE_TRIG});
		c = irq_cnt;
		pin_hold(1'b1, 60);
		pin_hold(1'b0, 300);
		check(16'(irq_cnt - c), 16'h0000);
		pin_hold(1'b1, 300);
		pin_hold(1'b0, 100);
		check(16'(irq_cnt - c), 16'h0001);
		rdchk(REG_DUTY_LO, 8'h34);
		rdchk(REG_DUTY_HI, 8'h12);
		run_ctl({1'b0, START_RISE, CLK_SEL_00, MODE_TRIG});
		pin_hold(1'b1, 60);
		pin_hold(1'b0, 300);
		check(16'(irq_cnt - c), 16'h0002);
	endtask : t_trig
	task automatic t_event();
		int c;
		wr(REG_PER_LO, 8'h03);
		wr(REG_PER_HI, 8'h00);
		run_ctl({1'b0, START_RISE, CLK_SEL_00, MODE_EVENT});
		c = irq_cnt;
		for (int i = 0; i < 2; i++) begin
			pin_hold(1'b1, 40);
			pin_hold(1'b0, 40);
		end
		pin_hold(1'b1, 10);
		pin_hold(1'b0, 40);
		check(16'(irq_cnt - c), 16'h0000);
		low_speed_mode <= 1'b1;
		pin_hold(1'b1, 10);
		pin_hold(1'b0, 40);
		check(16'(irq_cnt - c), 16'h0001);
		pin_hold(1'b1, 10);
		rdchk(REG_CNT_LO, 8'h01);
		low_speed_mode <= 1'b0;
		wr(REG_CTRL, 8'h00);
		// counter clears one edge after the stop write
		idle(1);
		rdchk(REG_CNT_LO, 8'h00);
		idle(10);
	endtask : t_event

	task automatic tally_and_finish();
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : tally_and_finish

	initial begin
		#400_000;
		n_errors++;
		tally_and_finish();
	end
	initial begin
		{rst_b, reg_wr, reg_rd, stop_mode_enter, low_speed_mode} = 5'h00;
		{reg_addr, reg_wdata} = 11'h000;
		{n_errors, check_count, irq_cnt} = '0;
		repeat (8) @(posedge sys_clk);
		rst_b <= 1'b1;
		idle(1);
		t_reset();
		t_timer();
		t_cap_stop();
		t_trig();
		t_event();
		tally_and_finish();
	end
endmodule : testbench

// file: core/t16tec_filter.sv
// Purpose: noise rejection and edge detection on the timer input pin
// Assumes: pin already synchronous to sys_clk
// Notes:   a level must hold FILT_CYC+1 samples before it is accepted
`timescale 1ns/10ps
module t16tec_filter
	import t16tec_pkg::*;
(
	// clock and reset
	input  wire logic sys_clk,
	input  wire logic rst_b,
	// carrier
	t16tec_if.flt     bus
);
	logic              lvl_q;
	logic              lvl_d;
	logic [FILT_W-1:0] hold_q;
	logic [FILT_W-1:0] hold_d;
	logic              rise_q;
	logic              fall_q;
	logic              differs;
	logic              settled;

	assign differs = (bus.pin_raw != lvl_q);
	assign settled = (hold_q == FILT_W'(FILT_CYC));
	// low-speed modes take the pin as is
	assign lvl_d   = bus.bypass ? bus.pin_raw : ((differs && settled) ? bus.pin_raw : lvl_q);
	assign hold_d  = (bus.bypass || !differs || settled) ? '0 : hold_q + FILT_W'(1);
	assign bus.pin_rise = rise_q;
	assign bus.pin_fall = fall_q;

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			lvl_q  <= 1'b0;
			hold_q <= '0;
			rise_q <= 1'b0;
			fall_q <= 1'b0;
		end else begin
			lvl_q  <= lvl_d;
			hold_q <= hold_d;
			rise_q <= lvl_d & ~lvl_q;
			fall_q <= ~lvl_d & lvl_q;
		end
	end
endmodule : t16tec_filter

// file: core/t16tec_prescale.sv
// Purpose: free-running source clock tick for the timer
// Assumes: divisors given in sys_clk cycles
// Notes:   runs even while the timer is stopped so buffered loads still land
`timescale 1ns/10ps
module t16tec_prescale
	import t16tec_pkg::*;
#(
	parameter int CYC00     = SRC00_CYC,
	parameter int CYC_SLOW  = SRC_SLOW_CYC
) (
	// clock and reset
	input  wire logic sys_clk,
	input  wire logic rst_b,
	// carrier
	t16tec_if.prs     bus
);
	logic [PRS_W-1:0] div_cnt_q;
	logic [PRS_W-1:0] div_cnt_d;
	logic [PRS_W-1:0] div_last;
	logic             tick_q;
	logic             wrap;

	// slow clock wins for code 00 when the slow path is selected
	assign div_last = (bus.clk_sel == CLK_SEL_00) ?
		(bus.slow_sel ? PRS_W'(CYC_SLOW - 1) : PRS_W'(CYC00 - 1)) :
		(bus.clk_sel == CLK_SEL_01) ? PRS_W'(SRC01_CYC - 1) : PRS_W'(SRC10_CYC - 1);
	// >= guards against a divisor change below the running count
	assign wrap      = (div_cnt_q >= div_last);
	assign div_cnt_d = wrap ? '0 : div_cnt_q + PRS_W'(1);
	assign bus.src_tick = tick_q;

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			div_cnt_q <= '0;
			tick_q    <= 1'b0;
		end else begin
			div_cnt_q <= div_cnt_d;
			tick_q    <= wrap;
		end
	end
endmodule : t16tec_prescale

// file: core/t16tec_top.sv
// Purpose: 16-bit up-counter timer with external trigger and event counting
// Assumes: byte register port, read data one cycle after the read strobe
// Notes:   window, pulse width and pulse output modes hold the counter at zero
`timescale 1ns/10ps
module t16tec_top
	import t16tec_pkg::*;
#(
	parameter int SRC00_CYCLES    = SRC00_CYC,
	parameter int SRC_SLOW_CYCLES = SRC_SLOW_CYC
) (
	// clock and reset
	input  wire logic       sys_clk,
	input  wire logic       rst_b,
	// register port
	input  wire logic [2:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output logic      [7:0] reg_rdata,
	// power state
	input  wire logic       stop_mode_enter,
	input  wire logic       low_speed_mode,
	// timer pin and interrupt
	input  wire logic       timer_input_pin,
	output logic            match_interrupt
);
	t16tec_if bus ();

	// register state
	logic [7:0]      timer_control_reg_q;
	logic [7:0]      timer_control_reg_d;
	logic [7:0]      aux_q;
	logic [7:0]      per_lo_buf_q;
	logic [7:0]      per_hi_buf_q;
	logic            per_pend_q;
	logic [15:0]     period_compare_reg_q;
	logic [7:0]      duty_lo_buf_q;
	logic [7:0]      duty_hi_buf_q;
	logic            duty_pend_q;
	logic [15:0]     duty_capture_reg_q;
	logic [15:0]     duty_capture_reg_d;
	logic [7:0]      rdata_q;
	logic [7:0]      rd_mux;

	// counter state
	logic [15:0]     cnt_q;
	logic [15:0]     cnt_d;
	t16tec_trig_st_t st_q;
	t16tec_trig_st_t st_d;
	logic            irq_q;
	logic            irq_d;

	// decode
	wire wr_ctrl    = reg_wr && (reg_addr == REG_CTRL);
	wire wr_per_lo  = reg_wr && (reg_addr == REG_PER_LO);
	wire wr_per_hi  = reg_wr && (reg_addr == REG_PER_HI);
	wire wr_duty_lo = reg_wr && (reg_addr == REG_DUTY_LO);
	wire wr_duty_hi = reg_wr && (reg_addr == REG_DUTY_HI);
	wire wr_aux     = reg_wr && (reg_addr == REG_AUX);

	// control fields
	wire [2:0] mode_select_field   = timer_control_reg_q[CTRL_MODE_LSB +: 3];
	wire [1:0] clock_select_field  = timer_control_reg_q[CTRL_CLK_LSB +: 2];
	wire [1:0] start_control_field = timer_control_reg_q[CTRL_START_LSB +: 2];
	wire       opt_bit             = timer_control_reg_q[CTRL_OPT_BIT];
	wire       prescaler_select    = aux_q[AUX_PRESC_BIT];

	wire running         = (start_control_field != START_STOP);
	wire is_timer        = (mode_select_field == MODE_TIMER);
	wire is_trig         = (mode_select_field == MODE_TRIG);
	wire is_event        = (mode_select_field == MODE_EVENT);
	wire is_window       = (mode_select_field == MODE_WINDOW);
	// the option bit doubles as capture enable and trigger stop enable
	wire auto_capture_enable = opt_bit && (is_timer || is_event || is_window);
	wire trigger_stop_enable = opt_bit && is_trig;

	// edge selection by the start field: falling only for code 11
	wire fall_sel  = (start_control_field == START_FALL);
	wire sel_edge  = fall_sel ? bus.pin_fall : bus.pin_rise;
	wire opp_edge  = fall_sel ? bus.pin_rise : bus.pin_fall;

	wire [15:0] cnt_inc   = cnt_q + 16'h0001;
	wire        inc_match = (cnt_inc == period_compare_reg_q);
	wire        cnt_match = (cnt_q == period_compare_reg_q);
	wire        src_tick  = bus.src_tick;
	// event mode takes the counting edge as its source clock
	wire        cap_tick  = is_event ? sel_edge : src_tick;

	// carrier
	assign bus.clk_sel  = clock_select_field;
	assign bus.slow_sel = prescaler_select || low_speed_mode;
	assign bus.pin_raw  = timer_input_pin;
	assign bus.bypass   = low_speed_mode;

	t16tec_prescale #(
		.CYC00    (SRC00_CYCLES),
		.CYC_SLOW (SRC_SLOW_CYCLES)
	) u_prescale (
		.sys_clk (sys_clk),
		.rst_b   (rst_b),
		.bus     (bus.prs)
	);

	t16tec_filter u_filter (
		.sys_clk (sys_clk),
		.rst_b   (rst_b),
		.bus     (bus.flt)
	);

	// control write; stop entry beats a same-cycle software start
	always_comb begin
		timer_control_reg_d = wr_ctrl ? reg_wdata : timer_control_reg_q;
		if (stop_mode_enter) begin
			timer_control_reg_d[CTRL_START_LSB +: 2] = START_STOP;
		end
	end

	// capture wins over a buffered load on the same tick
	always_comb begin
		duty_capture_reg_d = duty_capture_reg_q;
		if (src_tick && duty_pend_q) begin
			duty_capture_reg_d = {duty_hi_buf_q, duty_lo_buf_q};
		end
		if (running && auto_capture_enable && cap_tick) begin
			duty_capture_reg_d = cnt_q;
		end
	end

	// counting engine
	always_comb begin
		cnt_d = cnt_q;
		st_d  = st_q;
		irq_d = 1'b0;
		if (!running) begin
			cnt_d = 16'h0000;
			st_d  = TRG_IDLE;
		end else begin
			unique case (mode_select_field)
				MODE_TIMER: begin
					if (src_tick) begin
						cnt_d = inc_match ? 16'h0000 : cnt_inc;
						irq_d = inc_match;
					end
				end
				MODE_TRIG: begin
					unique case (st_q)
						TRG_IDLE: begin
							if (sel_edge) begin
								st_d  = TRG_RUN;
								cnt_d = 16'h0000;
							end
						end
						TRG_RUN: begin
							if (trigger_stop_enable && opp_edge) begin
								cnt_d = 16'h0000;
								st_d  = TRG_IDLE;
							end else if (src_tick) begin
								// repeated trigger edges are ignored while running
								cnt_d = inc_match ? 16'h0000 : cnt_inc;
								irq_d = inc_match;
								st_d  = inc_match ? TRG_IDLE : TRG_RUN;
							end
						end
					endcase
				end
				MODE_EVENT: begin
					if (sel_edge) begin
						cnt_d = cnt_inc;
					end else if (opp_edge && cnt_match) begin
						cnt_d = 16'h0000;
						irq_d = 1'b1;
					end
				end
				default: begin
					// window, pulse width and pulse output are not built here
					cnt_d = 16'h0000;
					st_d  = TRG_IDLE;
				end
			endcase
		end
	end

	// read selection
	assign rd_mux = (reg_addr == REG_CTRL)    ? timer_control_reg_q :
		(reg_addr == REG_PER_LO)  ? period_compare_reg_q[7:0] :
		(reg_addr == REG_PER_HI)  ? period_compare_reg_q[15:8] :
		(reg_addr == REG_DUTY_LO) ? duty_capture_reg_q[7:0] :
		(reg_addr == REG_DUTY_HI) ? duty_capture_reg_q[15:8] :
		(reg_addr == REG_AUX)     ? {aux_q[7:3], running, aux_q[1:0]} :
		(reg_addr == REG_CNT_LO)  ? cnt_q[7:0] : cnt_q[15:8];

	assign reg_rdata       = rdata_q;
	assign match_interrupt = irq_q;

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			timer_control_reg_q <= CTRL_RST;
			aux_q               <= AUX_RST;
			rdata_q             <= 8'h00;
		end else begin
			timer_control_reg_q <= timer_control_reg_d;
			if (wr_aux) begin
				aux_q <= {5'h00, 1'b0, reg_wdata[AUX_TFF_BIT], reg_wdata[AUX_PRESC_BIT]};
			end
			rdata_q <= reg_rd ? rd_mux : 8'h00;
		end
	end

	// period buffer: only the upper write arms the load
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			per_lo_buf_q         <= PER_RST[7:0];
			per_hi_buf_q         <= PER_RST[15:8];
			per_pend_q           <= 1'b0;
			period_compare_reg_q <= PER_RST;
		end else begin
			if (wr_per_lo) begin
				per_lo_buf_q <= reg_wdata;
			end
			if (wr_per_hi) begin
				per_hi_buf_q <= reg_wdata;
			end
			// a new upper write in the tick cycle keeps the load pending
			per_pend_q <= wr_per_hi || (per_pend_q && !src_tick);
			if (src_tick && per_pend_q) begin
				period_compare_reg_q <= {per_hi_buf_q, per_lo_buf_q};
			end
		end
	end

	// duty buffer, shared with the capture value
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			duty_lo_buf_q      <= DUTY_RST[7:0];
			duty_hi_buf_q      <= DUTY_RST[15:8];
			duty_pend_q        <= 1'b0;
			duty_capture_reg_q <= DUTY_RST;
		end else begin
			if (wr_duty_lo) begin
				duty_lo_buf_q <= reg_wdata;
			end
			if (wr_duty_hi) begin
				duty_hi_buf_q <= reg_wdata;
			end
			duty_pend_q        <= wr_duty_hi || (duty_pend_q && !src_tick);
			duty_capture_reg_q <= duty_capture_reg_d;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_q <= 16'h0000;
			st_q  <= TRG_IDLE;
			irq_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			st_q  <= st_d;
			irq_q <= irq_d;
		end
	end
endmodule : t16tec_top

// file: shared/t16tec_if.sv
// Purpose: carrier between the timer core, its prescaler and its input filter
// Assumes: all signals in the sys_clk domain
// Notes:   edges are one-cycle pulses
`timescale 1ns/10ps
interface t16tec_if;
	logic [1:0] clk_sel;
	logic       slow_sel;
	logic       src_tick;
	logic       pin_raw;
	logic       bypass;
	logic       pin_rise;
	logic       pin_fall;

	modport prs (input clk_sel, input slow_sel, output src_tick);
	modport flt (input pin_raw, input bypass, output pin_rise, output pin_fall);
	modport core (output clk_sel, output slow_sel, input src_tick,
		output pin_raw, output bypass, input pin_rise, input pin_fall);
endinterface : t16tec_if

// file: shared/t16tec_pkg.sv
// Purpose: constants, offsets and field layout of the 16-bit timer/event counter
// Assumes: sys_clk at 125 MHz, byte-wide register port with 3 address bits
// Notes:   counts are derived from times in ns at the sys_clk period
package t16tec_pkg;

	// clock and source-clock timing
	localparam int SYS_CLK_PERIOD_NS = 8;
	localparam int SRC00_NS          = 128000;
	localparam int SRC01_NS          = 8000;
	localparam int SRC10_NS          = 500;
	localparam int SRC_SLOW_NS       = 244140;
	localparam int SRC00_CYC         = SRC00_NS / SYS_CLK_PERIOD_NS;
	localparam int SRC01_CYC         = SRC01_NS / SYS_CLK_PERIOD_NS;
	localparam int SRC10_CYC         = SRC10_NS / SYS_CLK_PERIOD_NS;
	localparam int SRC_SLOW_CYC      = SRC_SLOW_NS / SYS_CLK_PERIOD_NS;
	localparam int PRS_W             = 15;

	// input noise rejection: pulses up to this width are dropped
	localparam int FILT_REJ_NS       = 250;
	localparam int FILT_CYC          = (FILT_REJ_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
	localparam int FILT_W            = 6;

	// register offsets
	localparam logic [2:0] REG_CTRL    = 3'h0;
	localparam logic [2:0] REG_PER_LO  = 3'h1;
	localparam logic [2:0] REG_PER_HI  = 3'h2;
	localparam logic [2:0] REG_DUTY_LO = 3'h3;
	localparam logic [2:0] REG_DUTY_HI = 3'h4;
	localparam logic [2:0] REG_AUX     = 3'h5;
	localparam logic [2:0] REG_CNT_LO  = 3'h6;
	localparam logic [2:0] REG_CNT_HI  = 3'h7;

	// control and aux register fields
	localparam int CTRL_MODE_LSB  = 0;
	localparam int CTRL_CLK_LSB   = 3;
	localparam int CTRL_START_LSB = 5;
	localparam int CTRL_OPT_BIT   = 7;
	localparam int AUX_PRESC_BIT  = 0;
	localparam int AUX_TFF_BIT    = 1;
	localparam int AUX_RUN_BIT    = 2;

	// reset values
	localparam logic [7:0]  CTRL_RST = 8'h00;
	localparam logic [7:0]  AUX_RST  = 8'h00;
	localparam logic [15:0] PER_RST  = 16'hffff;
	localparam logic [15:0] DUTY_RST = 16'hffff;

	// mode codes
	localparam logic [2:0] MODE_TIMER  = 3'h0;
	localparam logic [2:0] MODE_TRIG   = 3'h1;
	localparam logic [2:0] MODE_EVENT  = 3'h2;
	localparam logic [2:0] MODE_WINDOW = 3'h3;
	localparam logic [2:0] MODE_PWM    = 3'h4;
	localparam logic [2:0] MODE_PPG    = 3'h5;

	// start field codes
	localparam logic [1:0] START_STOP = 2'h0;
	localparam logic [1:0] START_CMD  = 2'h1;
	localparam logic [1:0] START_RISE = 2'h2;
	localparam logic [1:0] START_FALL = 2'h3;

	// clock select codes
	localparam logic [1:0] CLK_SEL_00 = 2'h0;
	localparam logic [1:0] CLK_SEL_01 = 2'h1;

	typedef enum logic {TRG_IDLE, TRG_RUN} t16tec_trig_st_t;

endpackage : t16tec_pkg
